// ===== core/tcm_defines.svh
// register offsets, field positions, reset values for timer control/mode
`ifndef TCM_DEFINES_SVH
`define TCM_DEFINES_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define TCM_OFF_CTRL 8'h88
`define TCM_OFF_MODE 8'h89
`define TCM_OFF_STAT 8'hA0
`define TCM_OFF_CLR 8'hA1
`define TCM_OFF_IEN 8'hA2
// ----------------------------------------------------------------------
// timer_control bit positions
// ----------------------------------------------------------------------
`define TCM_B_TF1 7
`define TCM_B_TR1 6
`define TCM_B_TF0 5
`define TCM_B_TR0 4
`define TCM_B_IE1 3
`define TCM_B_IT1 2
`define TCM_B_IE0 1
`define TCM_B_IT0 0
// ----------------------------------------------------------------------
// timer_mode field positions
// ----------------------------------------------------------------------
`define TCM_B_TIMER_ONE_GATE_ENABLE 7
`define TCM_B_CT1 6
`define TCM_B_M1_HI 5
`define TCM_B_M1_LO 4
`define TCM_B_TIMER_ZERO_GATE_ENABLE 3
`define TCM_B_CT0 2
`define TCM_B_M0_HI 1
`define TCM_B_M0_LO 0
// ----------------------------------------------------------------------
// event status bit positions
// ----------------------------------------------------------------------
`define TCM_EV_TF0 0
`define TCM_EV_TF1 1
`define TCM_EV_IE0 2
`define TCM_EV_IE1 3
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TCM_RST_CTRL 8'h00
`define TCM_RST_MODE 8'h00
`define TCM_RST_EV 4'h0
`define TCM_SYNC_RST 3'h7
`endif

// ===== core/tcm_pkg.sv
// types shared by the timer control and mode logic
package tcm_pkg;
  // timer operating mode field
  typedef enum logic [1:0] {
    TCM_MODE_VAR = 2'h0,
    TCM_MODE_RELOAD16 = 2'h1,
    TCM_MODE_RELOAD8 = 2'h2,
    TCM_MODE_STOP_SPLIT = 2'h3
  } tcm_mode_t;
endpackage : tcm_pkg

// ===== core/tcm_pin_sync.sv
// three-stage pin synchroniser with agreed level and falling pulse
`timescale 1ns/1ns
`default_nettype none
`include "tcm_defines.svh"
module tcm_pin_sync (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_pin,
  output logic o_level,
  output logic o_fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  // ----------------------------------------------------------------------
  // sampling chain
  // ----------------------------------------------------------------------
  // pins idle high, so reset to one to avoid a false edge at release
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      {s1_q, s2_q, s3_q} <= `TCM_SYNC_RST;
    end else begin
      {s1_q, s2_q, s3_q} <= {i_pin, s1_q, s2_q};
    end
  end
  // level changes only once stages two and three agree
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      lvl_q <= 1'b1;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end
  assign o_level = lvl_q;
  assign o_fall = lvl_q & (s2_q == s3_q) & ~s3_q;
endmodule : tcm_pin_sync
`default_nettype wire

// ===== core/tcm_timer_ctrl.sv
// timer control and mode registers with gating and interrupt flags
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "tcm_defines.svh"
module tcm_timer_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_timer_one_ovf,
  input wire logic i_timer_zero_ovf,
  input wire logic i_timer_zero_high_ovf,
  input wire logic i_timer_one_vector,
  input wire logic i_timer_zero_vector,
  input wire logic i_ext_irq_one_done,
  input wire logic i_ext_irq_zero_done,
  input wire logic i_ext_irq_one_pin,
  input wire logic i_ext_irq_zero_pin,
  input wire logic i_timer_one_count_pin,
  input wire logic i_timer_zero_count_pin,
  output logic o_timer_one_tick,
  output logic o_timer_zero_tick,
  output logic o_timer_zero_high_tick,
  output tcm_pkg::tcm_mode_t o_timer_one_mode,
  output tcm_pkg::tcm_mode_t o_timer_zero_mode,
  output logic o_timer_zero_reload_used,
  output logic o_ext_irq_one_flag,
  output logic o_ext_irq_zero_flag,
  output logic o_irq
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic tf1_q, tr1_q, tf0_q, tr0_q, ie1_q, it1_q, ie0_q, it0_q;
  logic [7:0] mode_q;
  logic [3:0] stat_q;
  logic [3:0] ien_q;
  logic [7:0] rdata_q;
  logic [3:0] pin_raw;
  logic [3:0] pin_lvl;
  logic [3:0] pin_fall;
  logic wr_ctrl, wr_mode, wr_clr, wr_ien;
  logic t0_split, tf1_set, tf0_set, ie1_set, ie0_set;
  logic run1, run0;
  logic [3:0] ev;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_ctrl = i_wr & hit(i_addr, `TCM_OFF_CTRL);
  assign wr_mode = i_wr & hit(i_addr, `TCM_OFF_MODE);
  assign wr_clr = i_wr & hit(i_addr, `TCM_OFF_CLR);
  assign wr_ien = i_wr & hit(i_addr, `TCM_OFF_IEN);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  assign pin_raw = {i_timer_one_count_pin, i_timer_zero_count_pin,
                    i_ext_irq_one_pin, i_ext_irq_zero_pin};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      tcm_pin_sync u_sync (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_pin(pin_raw[g]),
        .o_level(pin_lvl[g]),
        .o_fall(pin_fall[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // timer_mode register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      mode_q <= `TCM_RST_MODE;
    end else if (wr_mode) begin
      mode_q <= i_wdata;
    end
  end
  assign o_timer_one_mode =
    tcm_pkg::tcm_mode_t'(mode_q[`TCM_B_M1_HI:`TCM_B_M1_LO]);
  assign o_timer_zero_mode =
    tcm_pkg::tcm_mode_t'(mode_q[`TCM_B_M0_HI:`TCM_B_M0_LO]);
  assign t0_split = (o_timer_zero_mode == tcm_pkg::TCM_MODE_STOP_SPLIT);
  // only 16-bit reload touches the reload pair; mode 3 leaves it free
  assign o_timer_zero_reload_used =
    (o_timer_zero_mode == tcm_pkg::TCM_MODE_RELOAD16);

  // ----------------------------------------------------------------------
  // overflow flags
  // ----------------------------------------------------------------------
  // in split mode the high half of timer zero owns the timer one flag
  assign tf1_set = t0_split ? i_timer_zero_high_ovf : i_timer_one_ovf;
  assign tf0_set = i_timer_zero_ovf;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      tf1_q <= 1'b0;
    end else if (tf1_set) begin
      tf1_q <= 1'b1;
    end else if (i_timer_one_vector) begin
      tf1_q <= 1'b0;
    end else if (wr_ctrl) begin
      tf1_q <= i_wdata[`TCM_B_TF1];
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      tf0_q <= 1'b0;
    end else if (tf0_set) begin
      tf0_q <= 1'b1;
    end else if (i_timer_zero_vector) begin
      tf0_q <= 1'b0;
    end else if (wr_ctrl) begin
      tf0_q <= i_wdata[`TCM_B_TF0];
    end
  end

  // ----------------------------------------------------------------------
  // run and trigger type bits
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      {tr1_q, tr0_q, it1_q, it0_q} <= 4'h0;
    end else if (wr_ctrl) begin
      tr1_q <= i_wdata[`TCM_B_TR1];
      tr0_q <= i_wdata[`TCM_B_TR0];
      it1_q <= i_wdata[`TCM_B_IT1];
      it0_q <= i_wdata[`TCM_B_IT0];
    end
  end

  // ----------------------------------------------------------------------
  // external interrupt flags
  // ----------------------------------------------------------------------
  // level mode flag simply tracks a low pin; edge mode latches the fall
  assign ie1_set = it1_q ? pin_fall[1] : ~pin_lvl[1];
  assign ie0_set = it0_q ? pin_fall[0] : ~pin_lvl[0];
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ie1_q <= 1'b0;
    end else if (ie1_set) begin
      ie1_q <= 1'b1;
    end else if (i_ext_irq_one_done | ~it1_q) begin
      ie1_q <= 1'b0;
    end else if (wr_ctrl) begin
      ie1_q <= i_wdata[`TCM_B_IE1];
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ie0_q <= 1'b0;
    end else if (ie0_set) begin
      ie0_q <= 1'b1;
    end else if (i_ext_irq_zero_done | ~it0_q) begin
      ie0_q <= 1'b0;
    end else if (wr_ctrl) begin
      ie0_q <= i_wdata[`TCM_B_IE0];
    end
  end
  assign o_ext_irq_one_flag = ie1_q;
  assign o_ext_irq_zero_flag = ie0_q;

  // ----------------------------------------------------------------------
  // count enables
  // ----------------------------------------------------------------------
  assign run1 = tr1_q & (~mode_q[`TCM_B_TIMER_ONE_GATE_ENABLE] | pin_lvl[1])
              & (o_timer_one_mode != tcm_pkg::TCM_MODE_STOP_SPLIT);
  assign run0 = tr0_q & (~mode_q[`TCM_B_TIMER_ZERO_GATE_ENABLE] | pin_lvl[0]);
  // counter operation only ticks on an agreed falling pin sample
  assign o_timer_one_tick = run1 &
    (mode_q[`TCM_B_CT1] ? pin_fall[3] : 1'b1);
  assign o_timer_zero_tick = run0 &
    (mode_q[`TCM_B_CT0] ? pin_fall[2] : 1'b1);
  // split high half is a plain timer on the timer one run bit
  assign o_timer_zero_high_tick = t0_split & tr1_q;

  // ----------------------------------------------------------------------
  // event status, clear and enable
  // ----------------------------------------------------------------------
  assign ev = {ie1_set & ~ie1_q, ie0_set & ~ie0_q, tf1_set, tf0_set};
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      stat_q <= `TCM_RST_EV;
    end else begin
      // a new event wins over a clear in the same cycle
      stat_q <= (stat_q & ~(wr_clr ? i_wdata[3:0] : 4'h0)) | ev;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ien_q <= `TCM_RST_EV;
    end else if (wr_ien) begin
      ien_q <= i_wdata[3:0];
    end
  end
  assign o_irq = |(stat_q & ien_q);

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst | ~i_rd) begin
      rdata_q <= 8'h00;
    end else begin
      unique case (i_addr)
        `TCM_OFF_CTRL: rdata_q <= {tf1_q, tr1_q, tf0_q, tr0_q,
                                   ie1_q, it1_q, ie0_q, it0_q};
        `TCM_OFF_MODE: rdata_q <= mode_q;
        `TCM_OFF_STAT: rdata_q <= {4'h0, stat_q};
        `TCM_OFF_IEN: rdata_q <= {4'h0, ien_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sequence s_ctrl_write;
    wr_ctrl && tf1_set && !i_wdata[`TCM_B_TF1] ##1 1'b1;
  endsequence
  sequence s_fall1_edge;
    it1_q && pin_fall[1];
  endsequence

  property p_tf1_set;
    tf1_set |=> tf1_q;
  endproperty
  a_tf1_set: assert property (p_tf1_set)
    else $error("overflow one flag not set");
  property p_tf0_clear;
    i_timer_zero_vector && !tf0_set |=> !tf0_q;
  endproperty
  a_tf0_clear: assert property (p_tf0_clear)
    else $error("overflow zero flag not cleared on vector");
  property p_run1_write;
    wr_ctrl |=> tr1_q == $past(i_wdata[`TCM_B_TR1]);
  endproperty
  a_run1_write: assert property (p_run1_write)
    else $error("timer one run bit not written");
  property p_run0_off;
    !tr0_q |-> !o_timer_zero_tick;
  endproperty
  a_run0_off: assert property (p_run0_off)
    else $error("timer zero ticks while stopped");
  property p_ie1_edge;
    s_fall1_edge |=> ie1_q;
  endproperty
  a_ie1_edge: assert property (p_ie1_edge)
    else $error("edge one flag missed");
  property p_ie0_done;
    it0_q && i_ext_irq_zero_done && !ie0_set |=> !ie0_q;
  endproperty
  a_ie0_done: assert property (p_ie0_done)
    else $error("edge zero flag not cleared");
  property p_it1_level;
    !it1_q && !pin_lvl[1] ##1 !it1_q |-> ie1_q;
  endproperty
  a_it1_level: assert property (p_it1_level)
    else $error("level trigger one not tracked");
  property p_timer_one_gate_enable;
    mode_q[`TCM_B_TIMER_ONE_GATE_ENABLE] && !pin_lvl[1] |-> !o_timer_one_tick;
  endproperty
  a_timer_one_gate_enable: assert property (p_timer_one_gate_enable)
    else $error("gated timer one ticks with pin low");
  property p_count_sel;
    mode_q[`TCM_B_CT1] && !pin_fall[3] |-> !o_timer_one_tick;
  endproperty
  a_count_sel: assert property (p_count_sel)
    else $error("counter one ticks without falling pin");
  property p_mode3_stop;
    o_timer_one_mode == tcm_pkg::TCM_MODE_STOP_SPLIT |-> !o_timer_one_tick;
  endproperty
  a_mode3_stop: assert property (p_mode3_stop)
    else $error("timer one ticks in mode 3");
  property p_split_reload;
    t0_split |-> !o_timer_zero_reload_used;
  endproperty
  a_split_reload: assert property (p_split_reload)
    else $error("reload pair used in split mode");
  property p_set_wins;
    s_ctrl_write |-> tf1_q;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("software write beat hardware set");
  property p_reset_zero;
    @(posedge i_ref_clk) disable iff (1'b0)
      i_srst |=> {tf1_q, tr1_q, tf0_q, tr0_q, ie1_q,
      it1_q, ie0_q, it0_q} == `TCM_RST_CTRL && mode_q == `TCM_RST_MODE;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("registers not zero after reset");
endmodule : tcm_timer_ctrl
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the timer control and mode registers
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [6:0] ev = 7'h00;
  logic pin1 = 1'b1;
  logic pin0 = 1'b1;
  logic cnt1 = 1'b1;
  logic cnt0 = 1'b1;
  logic [7:0] o_rdata;
  logic tick1, tick0, tickh, rl_used, fl1, fl0, o_irq;
  tcm_pkg::tcm_mode_t md1, md0;
  int err_total = 0;
  int compares = 0;
  integer seed = 32'h9841;
  int mode_m;
  int mdl_mode = 0;
  int n;
  logic [7:0] rv;
  // ----------------------------------------------------------------
  // clock and design
  // ----------------------------------------------------------------
  always #50 i_ref_clk = ~i_ref_clk;
  tcm_timer_ctrl dut_u (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_timer_one_ovf(ev[0]), .i_timer_zero_ovf(ev[1]),
    .i_timer_zero_high_ovf(ev[6]), .i_timer_one_vector(ev[2]),
    .i_timer_zero_vector(ev[3]), .i_ext_irq_one_done(ev[4]),
    .i_ext_irq_zero_done(ev[5]), .i_ext_irq_one_pin(pin1),
    .i_ext_irq_zero_pin(pin0), .i_timer_one_count_pin(cnt1),
    .i_timer_zero_count_pin(cnt0), .o_timer_one_tick(tick1),
    .o_timer_zero_tick(tick0), .o_timer_zero_high_tick(tickh),
    .o_timer_one_mode(md1), .o_timer_zero_mode(md0),
    .o_timer_zero_reload_used(rl_used), .o_ext_irq_one_flag(fl1),
    .o_ext_irq_zero_flag(fl0), .o_irq(o_irq));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic chk_reg(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    if (a == 8'h89) begin
      mdl_mode = d;
    end
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : bus_rd
  task automatic pulse(input logic [6:0] m);
    @(posedge i_ref_clk);
    ev <= m;
    @(posedge i_ref_clk);
    ev <= 7'h00;
  endtask : pulse
  task automatic cyc(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask : cyc
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    bus_rd(8'h88, rv); chk_reg("ctrl reset", 8'h00, rv);
    bus_rd(8'h89, rv); chk_reg("mode reset", 8'h00, rv);
    cyc(1);
    chk_reg("rdata idle", 8'h00, o_rdata);
    // every mode code lands in both fields, other bits random
    for (int k = 0; k < 8; k++) begin
      mode_m = ($random(seed) & 8'hCC) | ((k % 4) * 8'h11);
      bus_wr(8'h89, mode_m[7:0]);
      bus_rd(8'h89, rv); chk_reg("mode", mdl_mode[7:0], rv);
      chk_reg("mode one", {6'h00, mdl_mode[5:4]}, {6'h00, md1});
      chk_reg("mode zero", {6'h00, mdl_mode[1:0]}, {6'h00, md0});
      chk_bit("reload use", mdl_mode[1:0] == 2'h1, rl_used);
    end
    bus_wr(8'h89, 8'h00);
    bus_wr(8'h55, 8'hFF);
    bus_rd(8'h55, rv); chk_reg("unmapped", 8'h00, rv);
    bus_rd(8'h89, rv); chk_reg("mode kept", mdl_mode[7:0], rv);
    // run bits, table of all four settings
    for (int i = 0; i < 4; i++) begin
      mode_m = (i[0] ? 8'h40 : 8'h00) | (i[1] ? 8'h10 : 8'h00);
      bus_wr(8'h88, mode_m[7:0]);
      #1 chk_bit("tick one", mode_m[6], tick1);
      chk_bit("tick zero", mode_m[4], tick0);
    end
    bus_wr(8'h88, 8'h00);
    // overflow flags, status, enable mask, vector clear
    bus_wr(8'hA2, 8'h0F);
    pulse(7'h03);
    bus_rd(8'h88, rv); chk_reg("ovf flags", 8'hA0, rv);
    bus_rd(8'hA0, rv); chk_reg("status", 8'h03, rv);
    chk_bit("irq on", 1'b1, o_irq);
    bus_wr(8'hA2, 8'h00);
    #1 chk_bit("irq masked", 1'b0, o_irq);
    bus_wr(8'hA2, 8'h0F);
    pulse(7'h0C);
    bus_rd(8'h88, rv); chk_reg("vector clr", 8'h00, rv);
    bus_wr(8'hA1, 8'h03);
    bus_rd(8'hA0, rv); chk_reg("status clr", 8'h00, rv);
    chk_bit("irq off", 1'b0, o_irq);
    // hardware set and software write in the same cycle
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= 8'h88;
    i_wdata <= 8'h00;
    ev <= 7'h01;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    ev <= 7'h00;
    bus_rd(8'h88, rv); chk_reg("set wins", 8'h80, rv);
    pulse(7'h04);
    bus_wr(8'hA1, 8'h0F);
    // edge triggered external interrupts
    bus_wr(8'h88, 8'h05);
    @(posedge i_ref_clk);
    pin1 <= 1'b0;
    pin0 <= 1'b0;
    n = 0;
    while (!(fl1 === 1'b1 && fl0 === 1'b1)) begin
      n++;
      if (n > 12) begin
        err_total++;
        finish_test();
      end
      cyc(1);
    end
    bus_rd(8'h88, rv); chk_reg("edge flags", 8'h0F, rv);
    bus_rd(8'hA0, rv); chk_reg("edge status", 8'h0C, rv);
    pulse(7'h30);
    bus_rd(8'h88, rv); chk_reg("edge done", 8'h05, rv);
    @(posedge i_ref_clk);
    pin1 <= 1'b1;
    pin0 <= 1'b1;
    cyc(8);
    chk_reg("rise no set", 8'h05, {4'h0, fl1, 1'b1, fl0, 1'b1});
    // level triggered: flag follows the low pin
    bus_wr(8'h88, 8'h00);
    @(posedge i_ref_clk);
    pin1 <= 1'b0;
    pin0 <= 1'b0;
    cyc(8);
    chk_bit("level one", 1'b1, fl1);
    chk_bit("level zero", 1'b1, fl0);
    @(posedge i_ref_clk);
    pin1 <= 1'b1;
    pin0 <= 1'b1;
    cyc(8);
    chk_bit("level one off", 1'b0, fl1);
    chk_bit("level zero off", 1'b0, fl0);
    // gating by the interrupt pin, then the stopped mode
    bus_wr(8'h89, 8'h80);
    bus_wr(8'h88, 8'h40);
    @(posedge i_ref_clk);
    pin1 <= 1'b0;
    cyc(8);
    chk_bit("gate low", 1'b0, tick1);
    @(posedge i_ref_clk);
    pin1 <= 1'b1;
    cyc(8);
    chk_bit("gate high", 1'b1, tick1);
    bus_wr(8'h89, 8'h30);
    #1 chk_bit("mode stop", 1'b0, tick1);
    // counter operation: one tick for one falling edge
    bus_wr(8'h89, 8'h40);
    #1 chk_bit("counter idle", 1'b0, tick1);
    @(posedge i_ref_clk);
    cnt1 <= 1'b0;
    n = 0;
    repeat (10) begin
      cyc(1);
      if (tick1 === 1'b1) n++;
    end
    chk_reg("count ticks", 8'h01, n[7:0]);
    // split timer zero: high half runs on run one and owns flag one
    // timer one select stays zero here
    bus_wr(8'h89, 8'h03);
    bus_wr(8'h88, 8'h40);
    #1 chk_bit("split tick", 1'b1, tickh);
    chk_bit("split reload", 1'b0, rl_used);
    pulse(7'h01);
    bus_rd(8'h88, rv); chk_reg("split ovf one", 8'h40, rv);
    pulse(7'h40);
    bus_rd(8'h88, rv); chk_reg("split ovf high", 8'hC0, rv);
    // timer zero counter operation: one tick for one falling edge
    bus_wr(8'h89, 8'h04);
    bus_wr(8'h88, 8'h10);
    #1 chk_bit("counter zero idle", 1'b0, tick0);
    @(posedge i_ref_clk);
    cnt0 <= 1'b0;
    n = 0;
    repeat (10) begin
      cyc(1);
      if (tick0 === 1'b1) n++;
    end
    chk_reg("count zero ticks", 8'h01, n[7:0]);
    finish_test();
  end
  // ----------------------------------------------------------------
  // hang guard
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    err_total++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
